/* File: common/power_seq_pkg.sv */
// Constants and carrier types for the power and reset sequencer
package power_seq_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLOCK_HZ          = 10_000_000;
	localparam int unsigned VERY_LONG_PRESS_MS = 5600;
	localparam int unsigned LONG_PRESS_MS      = 2000;
	localparam int unsigned WATCHDOG_MS        = 5000;
	localparam longint unsigned MS_CYCLES      = CLOCK_HZ / 1000;
	localparam longint unsigned VERY_LONG_CYCLES =
		VERY_LONG_PRESS_MS * MS_CYCLES;
	localparam longint unsigned LONG_CYCLES    = LONG_PRESS_MS * MS_CYCLES;
	localparam longint unsigned WATCHDOG_CYCLES = WATCHDOG_MS * MS_CYCLES;
	localparam int unsigned OSC_READY_CYCLES  = 16;
	localparam int unsigned COUNT_WIDTH       = 26;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam int unsigned CTRL_POWER_OFF = 0;
	localparam int unsigned CTRL_IO_HIGH   = 1;

	// ----------------------------------------
	// Regulator voltage settings
	// ----------------------------------------
	localparam logic IO_SETTING_1V8 = 1'h0;
	localparam logic IO_SETTING_3V3 = 1'h1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		off_clock_step,
		off_quiet_step,
		off_led_step,
		off_wait_release,
		off_watchdog_step,
		off_shutdown_loop
	} off_state_type;

	typedef struct packed {
		logic clock_1x;
		logic pll_enable;
		logic irq_enable;
		logic usb_analog_enable;
		logic regulator_shutdown;
		logic watchdog_enable;
	} power_ctrl_type;

	typedef struct packed {
		logic line_a;
		logic line_b;
		logic line_c;
	} led_type;

endpackage

/* File: testbench/power_partner.sv */
// Model of the button, reset circuit, crystal and supply rails
module power_partner #(
	parameter int RC_CYCLES  = 8,
	parameter int OSC_CYCLES = 4
) (
	input wire logic  clock,
	input wire logic  rails_up,
	input wire logic  press,
	input wire logic  core_supply_rail_low,
	input wire logic  strap,
	input wire logic  osc_run,
	output logic      power_button_input,
	output logic      external_reset_n,
	output logic      core_voltage_monitor,
	output logic      osc_amplitude_ok,
	output logic      port0_bit7_strap
);
	timeunit 1ns;
	timeprecision 1ns;
	int rc_q;
	int osc_q;
	// The RC holds reset low while the rails ramp
	always_ff @(posedge clock) begin
		if (!rails_up)
			rc_q <= 0;
		else if (rc_q < RC_CYCLES)
			rc_q <= rc_q + 1;
	end
	// Amplitude builds only while the amplifier runs
	always_ff @(posedge clock) begin
		if (osc_run !== 1'b1)
			osc_q <= 0;
		else if (osc_q < OSC_CYCLES)
			osc_q <= osc_q + 1;
	end
	assign external_reset_n = rc_q == RC_CYCLES;
	assign osc_amplitude_ok = osc_q == OSC_CYCLES;
	assign power_button_input = press;
	assign core_voltage_monitor = core_supply_rail_low;
	assign port0_bit7_strap = strap;
endmodule

/* File: testbench/power_seq_assertions.sv */
// Port checker for the power and reset sequencer
module power_seq_assertions
	import power_seq_pkg::*;
#(
	parameter longint unsigned VERY_LONG = 40
) (
	input wire logic            clock,
	input wire logic            rst,
	input wire logic            power_button_input,
	input wire logic            external_reset_n,
	input wire logic            core_voltage_monitor,
	input wire logic            port0_bit7_strap,
	input wire logic [3:0]      addr,
	input wire logic [7:0]      wdata,
	input wire logic            write_strobe,
	input wire logic            regulator_start,
	input wire logic            io_setting,
	input wire logic            osc_run,
	input wire logic            core_reset,
	input wire power_ctrl_type  power_ctrl,
	input wire logic            pins_drive_en,
	input wire logic            serial_tx,
	input wire led_type         leds,
	input wire logic            leds_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic        sw_off_q;
	int unsigned held_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			sw_off_q <= 1'b0;
		else if (write_strobe && addr == ADDR_CONTROL && wdata[CTRL_POWER_OFF])
			sw_off_q <= 1'b1;
	end
	// Saturates so a stuck button cannot wrap the count
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			held_q <= 0;
		else if (!power_button_input)
			held_q <= 0;
		else if (held_q < 1000)
			held_q <= held_q + 1;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_quiet;
		power_ctrl.clock_1x && !power_ctrl.pll_enable && !power_ctrl.irq_enable
			&& !power_ctrl.usb_analog_enable && leds == 3'h0;
	endsequence
	sequence s_released;
		serial_tx && pins_drive_en && leds_oe;
	endsequence
	property p_button;
		power_button_input [*4] |-> regulator_start;
	endproperty
	property p_very_long;
		held_q == VERY_LONG + 3 |-> ##[0:2] core_reset;
	endproperty
	property p_ext_reset;
		!external_reset_n [*5] |-> core_reset;
	endproperty
	property p_osc_first;
		$fell(core_reset) |-> $past(osc_run);
	endproperty
	property p_pins;
		$fell(core_reset) |-> ##[0:1] s_released;
	endproperty
	property p_strap;
		$fell(core_reset) |-> ##[1:3] io_setting == port0_bit7_strap;
	endproperty
	property p_sw_only;
		power_ctrl.regulator_shutdown |-> sw_off_q;
	endproperty
	property p_off_steps;
		$rose(power_ctrl.regulator_shutdown) |-> s_quiet;
	endproperty
	property p_wdog;
		$rose(power_ctrl.regulator_shutdown) |-> power_ctrl.watchdog_enable;
	endproperty
	property p_repeat;
		$rose(power_ctrl.regulator_shutdown)
			|-> ##[1:3] ($rose(power_ctrl.regulator_shutdown) || core_reset);
	endproperty
	property p_monitor;
		core_voltage_monitor [*5] |-> core_reset;
	endproperty
	a_button: assert property (p_button) else $error("button ignored");
	a_very_long: assert property (p_very_long) else $error("no reboot");
	a_ext_reset: assert property (p_ext_reset) else $error("early run");
	a_osc_first: assert property (p_osc_first) else $error("osc late");
	a_pins: assert property (p_pins) else $error("pins idle");
	a_strap: assert property (p_strap) else $error("io level");
	a_sw_only: assert property (p_sw_only) else $error("hw off");
	a_off_steps: assert property (p_off_steps) else $error("steps");
	a_wdog: assert property (p_wdog) else $error("no watchdog");
	a_repeat: assert property (p_repeat) else $error("one shot");
	a_monitor: assert property (p_monitor) else $error("monitor");
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the power and reset sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import power_seq_pkg::*;
	logic clock = 0, rst = 1, rails_up = 0, press = 0, core_supply_rail_low = 0, strap = 0;
	logic write_strobe = 0, read_strobe = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, got;
	logic power_button_input, external_reset_n, core_voltage_monitor;
	logic osc_amplitude_ok, port0_bit7_strap, regulator_start, io_setting;
	logic osc_run, core_reset, pins_drive_en, serial_tx, leds_oe;
	power_ctrl_type power_ctrl;
	led_type leds;
	int err_count = 0, checks_done = 0;
	power_partner i_power_partner (.clock, .rails_up, .press, .core_supply_rail_low,
		.strap, .osc_run, .power_button_input, .external_reset_n,
		.core_voltage_monitor, .osc_amplitude_ok, .port0_bit7_strap);
	power_button_reset_sequencer #(.VERY_LONG(40), .LONG_PRESS(20),
		.WATCHDOG(50)) i_power_button_reset_sequencer (.clock, .rst,
		.power_button_input, .external_reset_n, .core_voltage_monitor,
		.osc_amplitude_ok, .port0_bit7_strap, .addr, .wdata, .write_strobe,
		.read_strobe, .rdata, .regulator_start, .io_setting, .osc_run,
		.core_reset, .power_ctrl, .pins_drive_en, .serial_tx, .leds, .leds_oe);
	initial forever #50 clock = ~clock;
	task automatic close_out;
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, act);
		checks_done++;
		if (act !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic chk1(input string what, input logic exp, act);
		chk8(what, {7'h0, exp}, {7'h0, act});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Bounded wait on core reset (0) or regulator shutdown (1)
	task automatic wait_on(input int k, input logic v);
		int n = 0;
		while ((k == 0 ? core_reset : power_ctrl.regulator_shutdown) !== v) begin
			tick(1);
			n++;
			if (n > 200) begin
				err_count++;
				close_out();
			end
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic power_up(input logic s);
		@(posedge clock);
		rails_up <= 1'b0;
		strap <= s;
		tick(10);
		chk1("held reset", 1'b1, core_reset);
		chk1("pins idle", 1'b0, pins_drive_en);
		@(posedge clock);
		rails_up <= 1'b1;
		tick(6);
		chk1("osc early", 1'b0, osc_run);
		chk1("io start", IO_SETTING_1V8, io_setting);
		wait_on(0, 1'b0);
		chk1("osc run", 1'b1, osc_run);
		tick(3);
		chk1("tx", 1'b1, serial_tx);
		chk1("drive", 1'b1, pins_drive_en & leds_oe);
		chk8("leds on", 8'h07, 8'(leds));
		chk1("io strap", s, io_setting);
	endtask
	task automatic press_for(input int n);
		@(posedge clock);
		press <= 1'b1;
		tick(n);
		chk1("reg start", 1'b1, regulator_start);
		@(posedge clock);
		press <= 1'b0;
		tick(4);
	endtask
	task automatic presses;
		press_for(15);
		press_for(15);
		rd(ADDR_STATUS);
		chk1("short", 1'b0, got[0]);
		press_for(25);
		chk1("no hw off", 1'b0, power_ctrl.regulator_shutdown);
		rd(ADDR_STATUS);
		chk1("long", 1'b1, got[0]);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS);
		chk1("cleared", 1'b0, got[0]);
		rd(4'h8);
		chk8("unmapped", 8'h00, got);
		wr(ADDR_CONTROL, 8'h02);
		rd(ADDR_CONTROL);
		chk8("control", 8'h02, got);
		chk1("io sw", IO_SETTING_3V3, io_setting);
	endtask
	task automatic power_off;
		@(posedge clock);
		press <= 1'b1;
		wr(ADDR_CONTROL, 8'h01);
		tick(20);
		chk1("clock 1x", 1'b1, power_ctrl.clock_1x);
		chk1("pll", 1'b0, power_ctrl.pll_enable);
		chk1("irq", 1'b0, power_ctrl.irq_enable);
		chk1("usb", 1'b0, power_ctrl.usb_analog_enable);
		chk8("leds off", 8'h00, 8'(leds));
		chk1("held", 1'b0, power_ctrl.regulator_shutdown);
		@(posedge clock);
		press <= 1'b0;
		wait_on(1, 1'b1);
		chk1("wdog", 1'b1, power_ctrl.watchdog_enable);
		tick(2);
		chk1("again", 1'b1, power_ctrl.regulator_shutdown);
		wait_on(0, 1'b1);
		wait_on(0, 1'b0);
	endtask
	task automatic monitor_and_hold;
		@(posedge clock);
		core_supply_rail_low <= 1'b1;
		wait_on(0, 1'b1);
		press_for(5);
		chk1("reg idle", 1'b0, regulator_start);
		@(posedge clock);
		core_supply_rail_low <= 1'b0;
		wait_on(0, 1'b0);
		tick(1);
		chk1("reboot on", 1'b1, regulator_start);
		@(posedge clock);
		press <= 1'b1;
		tick(30);
		chk1("not yet", 1'b0, core_reset);
		wait_on(0, 1'b1);
		tick(2);
		@(posedge clock);
		press <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		power_up(1'b0);
		presses();
		power_up(1'b1);
		power_off();
		monitor_and_hold();
		close_out();
	end
endmodule
bind power_button_reset_sequencer power_seq_assertions #(
	.VERY_LONG(VERY_LONG)) i_power_seq_assertions (.clock, .rst,
	.power_button_input, .external_reset_n, .core_voltage_monitor,
	.port0_bit7_strap, .addr, .wdata, .write_strobe, .regulator_start,
	.io_setting, .osc_run, .core_reset, .power_ctrl, .pins_drive_en,
	.serial_tx, .leds, .leds_oe);

/* File: verilog/power_button_reset_sequencer.sv */
// Power-up, reset release and software power-off sequencer
// Summary of operation
// (RULE_01) Button high requests regulator start
// (RULE_02) Button held 5.6 s forces reboot reset
// (RULE_03) Reset held until external reset rises
// (RULE_04) Oscillator released after external reset
// (RULE_05) Core reset released after oscillator ready
// (RULE_06) Outputs leave high impedance at release
// (RULE_07) Serial transmit driven high at release
// (RULE_08) I/O regulator starts at 1.8 V
// (RULE_09) Strap pull-up selects 3.3 V at release
// (RULE_10) Only software sequence turns regulators off
// (RULE_11) Button held 2 s flags power-off request
// (RULE_12) First step: 1.0x clock, PLL off
// (RULE_13) Then interrupts off, USB and analog off
// (RULE_14) Then three LED lines driven low
// (RULE_15) Wait for button release before shutdown
// (RULE_16) Start 5 s watchdog if not running
// (RULE_17) Repeat regulator shutdown until power lost
// (RULE_18) Core monitor undervoltage asserts reset
// (RULE_19) Monitor release after shutdown reboots
// (RULE_20) External reset active low and asynchronous; code passes it through a two-stage synchroniser and acts on clock edges only
// (RULE_21) Press counter cleared when button low
module power_button_reset_sequencer
	import power_seq_pkg::*;
#(
	parameter longint unsigned VERY_LONG = VERY_LONG_CYCLES,
	parameter longint unsigned LONG_PRESS = LONG_CYCLES,
	parameter longint unsigned WATCHDOG = WATCHDOG_CYCLES
) (
	// Clock and reset
	input  wire logic           clock,
	input  wire logic           rst,
	// Pins
	input  wire logic           power_button_input,
	input  wire logic           external_reset_n,
	input  wire logic           core_voltage_monitor,
	input  wire logic           osc_amplitude_ok,
	input  wire logic           port0_bit7_strap,
	// Register port
	input  wire logic [3:0]     addr,
	input  wire logic [7:0]     wdata,
	input  wire logic           write_strobe,
	input  wire logic           read_strobe,
	output logic      [7:0]     rdata,
	// Regulators and oscillator
	output logic                regulator_start,
	output logic                io_setting,
	output logic                osc_run,
	output logic                core_reset,
	output power_ctrl_type      power_ctrl,
	// Pins leaving reset
	output logic                pins_drive_en,
	output logic                serial_tx,
	output led_type             leds,
	output logic                leds_oe
);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	// Every pin is asynchronous to the crystal, so each bit gets its own
	// two-stage chain and only the second stage is ever read
	localparam int SYNC_BITS = 5;
	logic [SYNC_BITS-1:0] pin_raw;
	logic [SYNC_BITS-1:0] synced;
	assign pin_raw = {port0_bit7_strap, power_button_input,
		external_reset_n, core_voltage_monitor, osc_amplitude_ok};
	for (genvar i = 0; i < SYNC_BITS; i++) begin : g_sync
		logic first_q;
		logic second_q;
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				first_q  <= 1'b0;
				second_q <= 1'b0;
			end else begin
				first_q  <= pin_raw[i];
				second_q <= first_q;
			end
		end
		assign synced[i] = second_q;
	end
	logic strap;
	logic button;
	logic ext_n;
	logic core_voltage_monitor_low;
	logic osc_ok;
	assign strap    = synced[4];
	assign button   = synced[3];
	assign ext_n    = synced[2];
	assign core_voltage_monitor_low = synced[1];
	assign osc_ok   = synced[0];

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	function automatic logic write_hit(
		input logic       strobe,
		input logic [3:0] a,
		input logic [3:0] target
	);
		return strobe && a == target;
	endfunction
	logic control_write;
	logic status_write;
	assign control_write = write_hit(write_strobe, addr, ADDR_CONTROL);
	assign status_write  = write_hit(write_strobe, addr, ADDR_STATUS);

	// ----------------------------------------
	// Press counter
	// ----------------------------------------
	logic [COUNT_WIDTH-1:0] press_q;
	logic                   long_req_q;
	logic                   reboot_q;
	logic                   long_hit;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			press_q  <= '0;
			reboot_q <= 1'b0;
		end else if (!button) begin
			press_q  <= '0; // RULE_21
			reboot_q <= 1'b0;
		end else begin
			if (press_q != COUNT_WIDTH'(VERY_LONG))
				press_q <= press_q + 1'b1;
			reboot_q <= (press_q == COUNT_WIDTH'(VERY_LONG - 1)); // RULE_02
		end
	end

	// A press reaching the long mark beats a clear in the same cycle,
	// so software never loses a request it has not yet seen
	assign long_hit = button && press_q == COUNT_WIDTH'(LONG_PRESS - 1);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			long_req_q <= 1'b0;
		end else if (long_hit) begin
			long_req_q <= 1'b1; // RULE_11
		end else if (status_write) begin
			long_req_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	logic [COUNT_WIDTH-1:0] wdog_q;
	logic                   wdog_run_q;
	logic                   wdog_fire;
	logic                   wdog_start;
	// Counts only while armed; expiry pulls the whole chip back into reset
	assign wdog_fire = wdog_run_q && wdog_q == COUNT_WIDTH'(WATCHDOG - 1);

	// ----------------------------------------
	// Reset chain
	// ----------------------------------------
	logic       hold_reset;
	logic [4:0] osc_cnt_q;
	logic       core_reset_q;
	logic       osc_run_q;
	// Any one cause holds the core; release waits for all of them
	assign hold_reset = !ext_n || core_voltage_monitor_low || reboot_q || wdog_fire;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			osc_run_q    <= 1'b0;
			osc_cnt_q    <= '0;
			core_reset_q <= 1'b1;
		end else if (hold_reset) begin
			osc_run_q    <= 1'b0; // RULE_03 RULE_18
			osc_cnt_q    <= '0;
			core_reset_q <= 1'b1;
		end else begin
			osc_run_q <= 1'b1; // RULE_04
			// Amplitude must stay good a while so a glitch cannot release
			if (!osc_ok)
				osc_cnt_q <= '0;
			else if (osc_cnt_q != 5'(OSC_READY_CYCLES))
				osc_cnt_q <= osc_cnt_q + 1'b1;
			if (osc_cnt_q == 5'(OSC_READY_CYCLES))
				core_reset_q <= 1'b0; // RULE_05 RULE_19
		end
	end

	// ----------------------------------------
	// Pin release and supply setting
	// ----------------------------------------
	logic io_setting_q;
	logic drive_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			io_setting_q <= IO_SETTING_1V8; // RULE_08
			drive_q      <= 1'b0;
		end else if (core_reset_q) begin
			io_setting_q <= IO_SETTING_1V8;
			drive_q      <= 1'b0;
		end else begin
			drive_q <= 1'b1; // RULE_06 RULE_07
			// Strap is judged once, on the first cycle out of reset
			if (!drive_q && strap)
				io_setting_q <= IO_SETTING_3V3; // RULE_09
			if (control_write)
				io_setting_q <= wdata[CTRL_IO_HIGH];
		end
	end

	// ----------------------------------------
	// Power-off sequence
	// ----------------------------------------
	off_state_type  state_q;
	logic           off_active_q;
	power_ctrl_type ctrl_q;
	led_type        leds_q;
	localparam led_type LEDS_ON  = '{line_a: 1'b1, line_b: 1'b1, line_c: 1'b1};
	localparam led_type LEDS_OFF = '{line_a: 1'b0, line_b: 1'b0, line_c: 1'b0};
	assign wdog_start = off_active_q && state_q == off_watchdog_step
		&& !wdog_run_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q      <= off_clock_step;
			off_active_q <= 1'b0;
			ctrl_q       <= '{clock_1x: 1'b0, pll_enable: 1'b1,
				irq_enable: 1'b1, usb_analog_enable: 1'b1,
				regulator_shutdown: 1'b0, watchdog_enable: 1'b0};
			leds_q       <= LEDS_ON;
		end else if (core_reset_q) begin
			state_q      <= off_clock_step;
			off_active_q <= 1'b0;
			ctrl_q       <= '{clock_1x: 1'b0, pll_enable: 1'b1,
				irq_enable: 1'b1, usb_analog_enable: 1'b1,
				regulator_shutdown: 1'b0, watchdog_enable: 1'b0};
			leds_q       <= LEDS_ON;
		end else if (!off_active_q) begin
			// Software alone starts power-off; the button never does
			if (control_write && wdata[CTRL_POWER_OFF])
				off_active_q <= 1'b1; // RULE_10
		end else begin
			case (state_q)
				off_clock_step: begin
					ctrl_q.clock_1x   <= 1'b1; // RULE_12
					ctrl_q.pll_enable <= 1'b0;
					state_q           <= off_quiet_step;
				end
				off_quiet_step: begin
					ctrl_q.irq_enable        <= 1'b0; // RULE_13
					ctrl_q.usb_analog_enable <= 1'b0;
					state_q                  <= off_led_step;
				end
				off_led_step: begin
					leds_q  <= LEDS_OFF; // RULE_14
					state_q <= off_wait_release;
				end
				off_wait_release: begin
					// A held button would switch the regulators straight on
					if (!button)
						state_q <= off_watchdog_step; // RULE_15
				end
				off_watchdog_step: begin
					ctrl_q.watchdog_enable <= 1'b1; // RULE_16
					state_q                <= off_shutdown_loop;
				end
				off_shutdown_loop: begin
					// Pulse repeatedly until power goes or watchdog bites
					ctrl_q.regulator_shutdown <=
						!ctrl_q.regulator_shutdown; // RULE_17
				end
				default: state_q <= off_clock_step;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wdog_q     <= '0;
			wdog_run_q <= 1'b0;
		end else if (wdog_fire) begin
			wdog_q     <= '0;
			wdog_run_q <= 1'b0;
		end else if (wdog_start) begin
			wdog_q     <= '0;
			wdog_run_q <= 1'b1; // RULE_16
		end else if (wdog_run_q) begin
			wdog_q <= wdog_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic regulator_start_q;
	logic tx_q;
	logic leds_oe_q;
	// Each pin driver has its own flop so that moving one release point
	// later cannot disturb the others
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_q      <= 1'b0;
			leds_oe_q <= 1'b0;
		end else if (core_reset_q) begin
			tx_q      <= 1'b0;
			leds_oe_q <= 1'b0;
		end else begin
			tx_q      <= 1'b1; // RULE_07
			leds_oe_q <= 1'b1; // RULE_06
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regulator_start_q <= 1'b0;
		end else begin
			// Reboot after monitor release re-enables the regulators
			regulator_start_q <= button
				|| (!core_reset_q && !ctrl_q.regulator_shutdown); // RULE_01
		end
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (read_strobe) begin
			case (addr)
				ADDR_CONTROL: rdata <= {6'h00, io_setting_q, off_active_q};
				ADDR_STATUS:  rdata <= {4'h0, wdog_run_q, button,
					osc_ok, long_req_q};
				default:      rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	assign regulator_start = regulator_start_q;
	assign io_setting      = io_setting_q;
	assign osc_run         = osc_run_q;
	assign core_reset      = core_reset_q;
	assign power_ctrl      = ctrl_q;
	assign pins_drive_en   = drive_q;
	assign serial_tx       = tx_q;
	assign leds            = leds_q;
	assign leds_oe         = leds_oe_q;

endmodule
